// ===== common/sysio_pkg.sv
// register map, field positions and reset values of the system and i/o control bank
package sysio_pkg;
  // register offsets, plain register space
  localparam logic [3:0] OFS_PORT5_DATA = 4'h5;
  localparam logic [3:0] OFS_SYS_CLK_PWR = 4'hd;
  localparam logic [3:0] OFS_IR_PIN_FUNC = 4'he;
  localparam logic [3:0] OFS_IRQ_FLAGS = 4'hf;
  // register offsets, control space page 0
  localparam logic [3:0] OFS_PORT5_DIR_SEG = 4'h5;
  localparam logic [3:0] OFS_PORT6_DIR = 4'h6;
  localparam logic [3:0] OFS_PORT7_DIR = 4'h7;
  localparam logic [3:0] OFS_PORT8_DIR = 4'h8;
  localparam logic [3:0] OFS_AUX_PTR = 4'h9;
  localparam logic [3:0] OFS_AUX_WIN = 4'ha;
  // system clock and power register fields
  localparam int CORE_OSC_BIT = 0;
  localparam int BOOST_LSB = 1;
  localparam int IDLE_SEL_BIT = 3;
  localparam int PLL_LSB = 4;
  localparam logic [7:0] SYS_CLK_PWR_MASK = 8'h7f;
  // ir and pin function register fields
  localparam int EXT0_FUNC_BIT = 0;
  localparam int EXT1_FUNC_BIT = 1;
  localparam int TMR_FUNC_BIT = 2;
  localparam int IR_FUNC_BIT = 3;
  localparam int LOW_ONLY_BIT = 5;
  localparam int CARRIER_BIT = 6;
  localparam int IR_EN_BIT = 7;
  localparam logic [7:0] IR_PIN_FUNC_MASK = 8'hef;
  // port 5 data register fields
  localparam int PAGE_SEL_BIT = 0;
  localparam logic [7:0] PORT5_DATA_MASK = 8'hf1;
  // flag positions
  localparam int FLAG_INPUT_CHANGE = 7;
  // pll multiplier codes for x130, x65 and x244
  localparam logic [7:0] PLL_MUL_130 = 8'h82;
  localparam logic [7:0] PLL_MUL_65 = 8'h41;
  localparam logic [7:0] PLL_MUL_244 = 8'hf4;
  // booster divider terminal counts: /1, /4, /8, /16
  localparam logic [3:0] BOOST_TERM_1 = 4'h0;
  localparam logic [3:0] BOOST_TERM_4 = 4'h3;
  localparam logic [3:0] BOOST_TERM_8 = 4'h7;
  localparam logic [3:0] BOOST_TERM_16 = 4'hf;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_PORT5_DIR_SEG = 8'hf0;
  // auxiliary ram geometry
  localparam int AUX_DEPTH = 128;
  localparam int AUX_AW = 7;
endpackage

// ===== hdl/sysio_ctrl_regs.sv
// system clock, ir/pin function, flag, port direction and auxiliary ram register bank
`timescale 1ns/10ps

// Contract
// RQ1: pll field gives sub clock x130, x65, x65/2, x65/4, or x244 when top bit set.
// RQ2: sleep instruction enters sleep with idle bit 0, idle with idle bit 1.
// RQ3: software places a no-operation right after every sleep instruction.
// RQ4: booster clock is sub clock divided by 1, 4, 8 or 16.
// RQ5: core oscillator bit 0 runs sub clock and stops main; 1 runs main.
// RQ6: ir disabled leaves the ir pin to port 5 direction bit 7.
// RQ7: carrier off: waveform from width timers, counter two runs free.
// RQ8: carrier on: low sections of the pulse carry counter two's carrier.
// RQ9: low-pulse-only bit ignores the high width timer.
// RQ10: ir pin function picks general i/o or ir output; direction bit 7 cleared.
// RQ11: timer input function picks general i/o or timer clock; direction bit 6 set.
// RQ12: external irq functions pick general i/o or irq input; direction bits 5/4 set.
// RQ13: each flag is set to one by its event, bit 7 down to 0.
// RQ14: bit 7 sets on any port 6 or port 8 input change.
// RQ15: bits 6..3 set on low width, high width, counter two, counter one underflow.
// RQ16: bits 2..0 set on irq pin 1, irq pin 0, general timer overflow.
// RQ17: direction bit 0 drives pin, 1 makes it input.
// RQ18: nibble selects hand port 7/8 nibbles to segments 16..31.
// RQ19: pointer holds seven bits, bit 7 reads zero.
// RQ20: data window reads and writes the byte at the pointer.
// RQ21: direction, segment and ram registers reachable only with page bit 0.
// RQ22: port 5 data bit 0 picks control page 0 or 1.
// RQ23: flags stay set until written zero; writing one does nothing.
module sysio_ctrl_regs (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic ctrl_space,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // core and clock control
  input wire logic sleep_instruction,
  input wire logic sub_clock_tick,
  output logic sleep_enter,
  output logic idle_enter,
  output logic core_osc_select,
  output logic main_osc_run,
  output logic [7:0] pll_mult_select,
  output logic [1:0] pll_post_shift,
  output logic booster_tick,
  // ir generator
  input wire logic ir_pulse_level,
  input wire logic carrier_level,
  output logic infrared_gen_enable,
  output logic carrier_mod_enable,
  output logic low_pulse_only,
  output logic high_timer_used,
  output logic counter_two_free_run,
  // pin functions
  output logic ir_pin_function,
  output logic timer_input_pin_function,
  output logic ext_irq1_pin_function,
  output logic ext_irq0_pin_function,
  output logic timer_pin_clk,
  output logic ext_irq1_in,
  output logic ext_irq0_in,
  // ports
  input wire logic [7:4] port5_in,
  input wire logic [7:0] port6_in,
  input wire logic [7:0] port8_in,
  output logic [7:4] port5_out,
  output logic [7:4] port5_oe,
  output logic [7:0] port6_oe,
  output logic [7:0] port7_oe,
  output logic [7:0] port8_oe,
  output logic [3:0] segment_nibble_sel,
  // interrupt events, bits 6..0
  input wire logic [6:0] irq_events
);
  import sysio_pkg::*;

  logic rst_meta_ff;
  logic rst_sync_n;
  logic [7:0] port5_data_ff;
  logic [7:0] sys_clk_pwr_ff;
  logic [7:0] ir_pin_func_ff;
  logic [7:0] irq_flags_ff;
  logic [7:0] port5_dir_seg_ff;
  logic [7:0] port6_dir_ff;
  logic [7:0] port7_dir_ff;
  logic [7:0] port8_dir_ff;
  logic [AUX_AW-1:0] aux_ptr_ff;
  logic [7:0] aux_mem [AUX_DEPTH];
  logic [7:0] rdata_ff;
  logic [7:0] port6_prev_ff;
  logic [7:0] port8_prev_ff;
  logic prev_valid_ff;
  logic [3:0] boost_cnt_ff;
  logic boost_tick_ff;
  logic sleep_ff;
  logic idle_ff;
  logic page0;
  logic wr_plain;
  logic wr_ctrl;
  logic [7:0] flag_set;
  logic [3:0] boost_term;
  logic ir_wave;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_n <= rst_meta_ff;
    end
  end

  assign page0 = ~port5_data_ff[PAGE_SEL_BIT]; // RQ22
  assign wr_plain = reg_wr & ~ctrl_space;
  // page 1 control registers live elsewhere, so this bank ignores them
  assign wr_ctrl = reg_wr & ctrl_space & page0; // RQ21

  // plain register space
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      port5_data_ff <= RST_ZERO;
      sys_clk_pwr_ff <= RST_ZERO;
      ir_pin_func_ff <= RST_ZERO;
    end else if (wr_plain) begin
      if (reg_addr == OFS_PORT5_DATA)
        port5_data_ff <= reg_wdata & PORT5_DATA_MASK; // RQ22
      if (reg_addr == OFS_SYS_CLK_PWR)
        sys_clk_pwr_ff <= reg_wdata & SYS_CLK_PWR_MASK;
      if (reg_addr == OFS_IR_PIN_FUNC)
        ir_pin_func_ff <= reg_wdata & IR_PIN_FUNC_MASK;
    end
  end

  // flags: hardware set beats a software clear in the same cycle
  // pins idling high would look like a change against the reset value of the history flops
  assign flag_set = {prev_valid_ff & ((|((port6_in ^ port6_prev_ff) & port6_dir_ff)) |
                     (|((port8_in ^ port8_prev_ff) & port8_dir_ff))), irq_events}; // RQ14

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      port6_prev_ff <= RST_ZERO;
      port8_prev_ff <= RST_ZERO;
      prev_valid_ff <= 1'b0;
    end else begin
      port6_prev_ff <= port6_in;
      port8_prev_ff <= port8_in;
      prev_valid_ff <= 1'b1;
    end
  end

  generate
    for (genvar i = 0; i < 8; i++) begin : g_flag
      always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n)
          irq_flags_ff[i] <= 1'b0;
        else if (flag_set[i])
          irq_flags_ff[i] <= 1'b1; // RQ13 RQ15 RQ16
        else if (wr_plain && reg_addr == OFS_IRQ_FLAGS && !reg_wdata[i])
          irq_flags_ff[i] <= 1'b0; // RQ23
      end
    end
  endgenerate

  // control space, page 0
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      port5_dir_seg_ff <= RST_PORT5_DIR_SEG;
      port6_dir_ff <= RST_DIR;
      port7_dir_ff <= RST_DIR;
      port8_dir_ff <= RST_DIR;
      aux_ptr_ff <= RST_ZERO[AUX_AW-1:0];
    end else if (wr_ctrl) begin
      case (reg_addr)
        OFS_PORT5_DIR_SEG: port5_dir_seg_ff <= reg_wdata;
        OFS_PORT6_DIR: port6_dir_ff <= reg_wdata;
        OFS_PORT7_DIR: port7_dir_ff <= reg_wdata;
        OFS_PORT8_DIR: port8_dir_ff <= reg_wdata;
        OFS_AUX_PTR: aux_ptr_ff <= reg_wdata[AUX_AW-1:0]; // RQ19
        default: ;
      endcase
    end
  end

  // auxiliary ram has no reset; contents are undefined until written
  always_ff @(posedge ref_clk) begin
    if (wr_ctrl && reg_addr == OFS_AUX_WIN)
      aux_mem[aux_ptr_ff] <= reg_wdata; // RQ20
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      rdata_ff <= RST_ZERO;
    else if (!reg_rd)
      rdata_ff <= RST_ZERO;
    else if (!ctrl_space) begin
      case (reg_addr)
        OFS_PORT5_DATA: rdata_ff <= {port5_in, 3'h0, port5_data_ff[PAGE_SEL_BIT]};
        OFS_SYS_CLK_PWR: rdata_ff <= sys_clk_pwr_ff;
        OFS_IR_PIN_FUNC: rdata_ff <= ir_pin_func_ff;
        OFS_IRQ_FLAGS: rdata_ff <= irq_flags_ff;
        default: rdata_ff <= RST_ZERO;
      endcase
    end else if (page0) begin // RQ21
      case (reg_addr)
        OFS_PORT5_DIR_SEG: rdata_ff <= port5_dir_seg_ff;
        OFS_PORT6_DIR: rdata_ff <= port6_dir_ff;
        OFS_PORT7_DIR: rdata_ff <= port7_dir_ff;
        OFS_PORT8_DIR: rdata_ff <= port8_dir_ff;
        OFS_AUX_PTR: rdata_ff <= {1'b0, aux_ptr_ff}; // RQ19
        OFS_AUX_WIN: rdata_ff <= aux_mem[aux_ptr_ff]; // RQ20
        default: rdata_ff <= RST_ZERO;
      endcase
    end else
      rdata_ff <= RST_ZERO;
  end
  assign reg_rdata = rdata_ff;

  // sleep or idle entry, one-cycle pulses
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sleep_ff <= 1'b0;
      idle_ff <= 1'b0;
    end else begin
      sleep_ff <= sleep_instruction & ~sys_clk_pwr_ff[IDLE_SEL_BIT]; // RQ2
      idle_ff <= sleep_instruction & sys_clk_pwr_ff[IDLE_SEL_BIT]; // RQ2
    end
  end
  assign sleep_enter = sleep_ff;
  assign idle_enter = idle_ff;

  assign core_osc_select = sys_clk_pwr_ff[CORE_OSC_BIT]; // RQ5
  assign main_osc_run = sys_clk_pwr_ff[CORE_OSC_BIT]; // RQ5

  // pll multiplier plus a right shift for the halved and quartered settings
  always_comb begin
    pll_mult_select = PLL_MUL_65;
    pll_post_shift = 2'h0;
    if (sys_clk_pwr_ff[PLL_LSB+2])
      pll_mult_select = PLL_MUL_244; // RQ1
    else if (sys_clk_pwr_ff[PLL_LSB+1 -: 2] == 2'h0)
      pll_mult_select = PLL_MUL_130; // RQ1
    else
      pll_post_shift = sys_clk_pwr_ff[PLL_LSB+1 -: 2] - 2'h1; // RQ1
  end

  // booster divider counts sub clock ticks
  always_comb begin
    case (sys_clk_pwr_ff[BOOST_LSB+1 -: 2])
      2'h0: boost_term = BOOST_TERM_1;
      2'h1: boost_term = BOOST_TERM_4;
      2'h2: boost_term = BOOST_TERM_8;
      default: boost_term = BOOST_TERM_16;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      boost_cnt_ff <= 4'h0;
      boost_tick_ff <= 1'b0;
    end else begin
      boost_tick_ff <= sub_clock_tick && boost_cnt_ff >= boost_term; // RQ4
      if (sub_clock_tick)
        boost_cnt_ff <= (boost_cnt_ff >= boost_term) ? 4'h0 : boost_cnt_ff + 4'h1; // RQ4
    end
  end
  assign booster_tick = boost_tick_ff;

  // ir generator control
  assign infrared_gen_enable = ir_pin_func_ff[IR_EN_BIT];
  assign carrier_mod_enable = ir_pin_func_ff[CARRIER_BIT];
  assign counter_two_free_run = ~ir_pin_func_ff[CARRIER_BIT]; // RQ7
  assign low_pulse_only = ir_pin_func_ff[LOW_ONLY_BIT];
  assign high_timer_used = ~ir_pin_func_ff[LOW_ONLY_BIT]; // RQ9
  // carrier fills the low sections only; high sections stay high
  assign ir_wave = ir_pin_func_ff[CARRIER_BIT] ?
                   (ir_pulse_level | carrier_level) : ir_pulse_level; // RQ7 RQ8

  // pin functions
  assign ir_pin_function = ir_pin_func_ff[IR_FUNC_BIT];
  assign timer_input_pin_function = ir_pin_func_ff[TMR_FUNC_BIT];
  assign ext_irq1_pin_function = ir_pin_func_ff[EXT1_FUNC_BIT];
  assign ext_irq0_pin_function = ir_pin_func_ff[EXT0_FUNC_BIT];
  assign timer_pin_clk = ir_pin_func_ff[TMR_FUNC_BIT] & port5_in[6]; // RQ11
  assign ext_irq1_in = ir_pin_func_ff[EXT1_FUNC_BIT] & port5_in[5]; // RQ12
  assign ext_irq0_in = ir_pin_func_ff[EXT0_FUNC_BIT] & port5_in[4]; // RQ12

  // port 5: the ir pin takes the waveform only while both ir bits are set
  always_comb begin
    port5_out = port5_data_ff[7:4];
    port5_oe = ~port5_dir_seg_ff[7:4]; // RQ17
    if (ir_pin_func_ff[IR_FUNC_BIT] && ir_pin_func_ff[IR_EN_BIT])
      port5_out[7] = ir_wave; // RQ10
    // with ir off the pin falls back to its port 5 data bit 7
    if (ir_pin_func_ff[IR_FUNC_BIT] && !ir_pin_func_ff[IR_EN_BIT])
      port5_out[7] = port5_data_ff[7]; // RQ6
  end

  assign port6_oe = ~port6_dir_ff; // RQ17
  assign segment_nibble_sel = port5_dir_seg_ff[3:0]; // RQ18
  // a nibble handed to the segment driver is never driven by the port
  assign port7_oe = ~port7_dir_ff & ~{{4{port5_dir_seg_ff[1]}}, {4{port5_dir_seg_ff[0]}}}; // RQ18
  assign port8_oe = ~port8_dir_ff & ~{{4{port5_dir_seg_ff[3]}}, {4{port5_dir_seg_ff[2]}}}; // RQ18

  // checks
  sleep_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    sleep_instruction |=> (sleep_enter != idle_enter) &&
    (idle_enter == $past(sys_clk_pwr_ff[IDLE_SEL_BIT])))
    else $error("sleep or idle pulse wrong"); // RQ2
  flag_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (irq_flags_ff[0] && !(wr_plain && reg_addr == OFS_IRQ_FLAGS && !reg_wdata[0]))
    |=> irq_flags_ff[0])
    else $error("flag lost without a zero write"); // RQ23
  flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    irq_events[3] |=> irq_flags_ff[3])
    else $error("event did not set flag"); // RQ15
  flag_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (wr_plain && reg_addr == OFS_IRQ_FLAGS && reg_wdata == 8'h00 && flag_set == 8'h00)
    |=> irq_flags_ff == 8'h00)
    else $error("zero write did not clear flags"); // RQ23
  change_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (port6_dir_ff[0] && $changed(port6_in[0])) |-> ##1 irq_flags_ff[FLAG_INPUT_CHANGE])
    else $error("input change missed"); // RQ14
  page_guard_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (reg_wr && ctrl_space && port5_data_ff[PAGE_SEL_BIT]) |=> $stable(port6_dir_ff))
    else $error("page 1 write reached page 0"); // RQ21
  ptr_top_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (reg_rd && ctrl_space && page0 && reg_addr == OFS_AUX_PTR) |=> !reg_rdata[7])
    else $error("pointer bit 7 not zero"); // RQ19
  ram_back_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (wr_ctrl && reg_addr == OFS_AUX_WIN) ##1
    (reg_rd && ctrl_space && page0 && reg_addr == OFS_AUX_WIN && $stable(aux_ptr_ff))
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("window read back mismatch"); // RQ20
  pll_top_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    sys_clk_pwr_ff[PLL_LSB+2] |-> pll_mult_select == PLL_MUL_244 && pll_post_shift == 2'h0)
    else $error("pll top setting wrong"); // RQ1
  boost_div_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (booster_tick && sys_clk_pwr_ff[BOOST_LSB+1 -: 2] == 2'h1 && $stable(sys_clk_pwr_ff))
    |-> boost_cnt_ff == 4'h0)
    else $error("booster divider phase wrong"); // RQ4
  seg_oe_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    port5_dir_seg_ff[3] |-> port8_oe[7:4] == 4'h0)
    else $error("segment nibble still driven"); // RQ18

  idle_seen_c: cover property (@(posedge ref_clk) disable iff (!rst_sync_n) idle_enter);
  flag_race_c: cover property (@(posedge ref_clk) disable iff (!rst_sync_n)
    irq_events[3] && wr_plain && reg_addr == OFS_IRQ_FLAGS);
  ram_read_c: cover property (@(posedge ref_clk) disable iff (!rst_sync_n)
    reg_rd && ctrl_space && page0 && reg_addr == OFS_AUX_WIN);
endmodule // sysio_ctrl_regs

// ===== verification/sysio_ctrl_regs_tb.sv
// self-checking testbench of the system, pin function, flag, direction and aux ram bank
`timescale 1ns/10ps
module testbench;
  import sysio_pkg::*;
  logic ref_clk, rst_n, ctrl_space, reg_wr, reg_rd, sleep_instruction;
  logic sub_clock_tick = 1'b0;
  logic ir_pulse_level, carrier_level;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, port6_in, port8_in;
  logic [7:4] port5_in, port5_out, port5_oe;
  logic [6:0] irq_events;
  logic sleep_enter, idle_enter, core_osc_select, main_osc_run, booster_tick;
  logic [7:0] pll_mult_select, port6_oe, port7_oe, port8_oe;
  logic [1:0] pll_post_shift;
  logic [3:0] segment_nibble_sel;
  logic infrared_gen_enable, carrier_mod_enable, low_pulse_only, high_timer_used;
  logic counter_two_free_run, ir_pin_function, timer_input_pin_function;
  logic ext_irq1_pin_function, ext_irq0_pin_function, timer_pin_clk, ext_irq1_in, ext_irq0_in;
  int n_fail = 0;
  int total_checks = 0;
  int i, c, n, d, ds, v, a, fm;
  int mem_m[128];
  int dir_m[9];
  int q[$];

  sysio_ctrl_regs sysio_ctrl_regs_i (
    .ref_clk, .rst_n, .ctrl_space, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sleep_instruction, .sub_clock_tick, .sleep_enter, .idle_enter, .core_osc_select,
    .main_osc_run, .pll_mult_select, .pll_post_shift, .booster_tick, .ir_pulse_level,
    .carrier_level, .infrared_gen_enable, .carrier_mod_enable, .low_pulse_only,
    .high_timer_used, .counter_two_free_run, .ir_pin_function, .timer_input_pin_function,
    .ext_irq1_pin_function, .ext_irq0_pin_function, .timer_pin_clk, .ext_irq1_in,
    .ext_irq0_in, .port5_in, .port6_in, .port8_in, .port5_out, .port5_oe, .port6_oe,
    .port7_oe, .port8_oe, .segment_nibble_sel, .irq_events
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // sub clock tick every other cycle, so booster spacing in cycles is twice the divider
  always @(posedge ref_clk) sub_clock_tick <= ~sub_clock_tick;

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic s, input logic e);
    chk({7'h0, s}, {7'h0, e});
  endtask

  task automatic wr(input logic cs, input logic [3:0] ad, input logic [7:0] wd);
    @(posedge ref_clk);
    ctrl_space <= cs;
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input logic cs, input logic [3:0] ad, input logic [7:0] e);
    @(posedge ref_clk);
    ctrl_space <= cs;
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  task automatic wait_tick(output int cnt);
    cnt = 0;
    do begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end while (booster_tick !== 1'b1 && cnt < 100);
    if (cnt >= 100) begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  task automatic do_reset;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdchk(1'b1, OFS_PORT5_DIR_SEG, RST_PORT5_DIR_SEG);
    for (int p = 6; p <= 8; p++) rdchk(1'b1, 4'(p), RST_DIR);
    rdchk(1'b1, OFS_AUX_PTR, RST_ZERO);
    rdchk(1'b0, OFS_SYS_CLK_PWR, RST_ZERO);
    rdchk(1'b0, OFS_IR_PIN_FUNC, RST_ZERO);
    rdchk(1'b0, OFS_IRQ_FLAGS, RST_ZERO);
    chk(port6_oe | port7_oe | port8_oe, 8'h00);
    chk({4'h0, segment_nibble_sel}, 8'h00);
  endtask

  initial begin
    {rst_n, ctrl_space, reg_wr, reg_rd, sleep_instruction, ir_pulse_level,
      carrier_level, reg_addr, reg_wdata, port5_in, port6_in, port8_in, irq_events} = '0;
    void'($urandom(64));
    do_reset();
    for (c = 0; c < 8; c++) begin
      v = (c << 4) | ($urandom & 8'h8f);
      wr(1'b0, OFS_SYS_CLK_PWR, 8'(v));
      rdchk(1'b0, OFS_SYS_CLK_PWR, 8'(v) & SYS_CLK_PWR_MASK);
      chk(pll_mult_select, (c >= 4) ? PLL_MUL_244 : (c == 0) ? PLL_MUL_130 : PLL_MUL_65);
      chk({6'h0, pll_post_shift}, (c >= 4 || c == 0) ? 8'h00 : 8'(c - 1));
      chk1(core_osc_select, v[0]);
      chk1(main_osc_run, v[0]);
      @(posedge ref_clk);
      sleep_instruction <= 1'b1;
      @(posedge ref_clk);
      sleep_instruction <= 1'b0;
      #1;
      chk1(sleep_enter, ~v[3]);
      chk1(idle_enter, v[3]);
    end
    for (c = 0; c < 4; c++) begin
      wr(1'b0, OFS_SYS_CLK_PWR, 8'(c << BOOST_LSB));
      wait_tick(n);
      wait_tick(n);
      chk(8'(n), 8'(2 * ((c == 0) ? 1 : (4 << (c - 1)))));
    end
    for (i = 0; i < 8; i++) begin
      v = $urandom & 8'hff;
      ds = $urandom & 8'h7f;
      d = $urandom & 8'hf0;
      for (c = 6; c <= 8; c++) dir_m[c] = $urandom & 8'hff;
      wr(1'b0, OFS_PORT5_DATA, 8'(d));
      wr(1'b0, OFS_IR_PIN_FUNC, 8'(v));
      wr(1'b1, OFS_PORT5_DIR_SEG, 8'(ds));
      for (c = 6; c <= 8; c++) wr(1'b1, 4'(c), 8'(dir_m[c]));
      @(posedge ref_clk);
      port5_in <= 4'($urandom);
      ir_pulse_level <= 1'($urandom);
      carrier_level <= 1'($urandom);
      #1;
      chk1(infrared_gen_enable, v[7]);
      chk1(carrier_mod_enable, v[6]);
      chk1(counter_two_free_run, ~v[6]);
      chk1(low_pulse_only, v[5]);
      chk1(high_timer_used, ~v[5]);
      chk({4'h0, ir_pin_function, timer_input_pin_function, ext_irq1_pin_function,
        ext_irq0_pin_function}, 8'(v & 8'h0f));
      chk1(timer_pin_clk, port5_in[6] & v[2]);
      chk1(ext_irq1_in, port5_in[5] & v[1]);
      chk1(ext_irq0_in, port5_in[4] & v[0]);
      // carrier fills the low sections, so it is or-ed into the waveform
      chk1(port5_out[7], (v[7] & v[3]) ? (ir_pulse_level | (v[6] & carrier_level)) : d[7]);
      chk({5'h0, port5_out[6:4]}, 8'((d >> 4) & 7));
      chk({4'h0, port5_oe}, 8'((~ds >> 4) & 15));
      chk(port6_oe, ~8'(dir_m[6]));
      chk(port7_oe, ~8'(dir_m[7]) & {{4{~ds[1]}}, {4{~ds[0]}}});
      chk(port8_oe, ~8'(dir_m[8]) & {{4{~ds[3]}}, {4{~ds[2]}}});
      chk({4'h0, segment_nibble_sel}, 8'(ds & 15));
      rdchk(1'b0, OFS_IR_PIN_FUNC, 8'(v) & IR_PIN_FUNC_MASK);
      rdchk(1'b1, OFS_PORT5_DIR_SEG, 8'(ds));
      for (c = 6; c <= 8; c++) rdchk(1'b1, 4'(c), 8'(dir_m[c]));
      rdchk(1'b0, OFS_PORT5_DATA, {port5_in, 4'h0});
    end
    for (i = 0; i < 13; i++) begin
      a = (i == 12) ? 8'hff : ($urandom & 8'hff);
      d = $urandom & 8'hff;
      wr(1'b1, OFS_AUX_PTR, 8'(a));
      rdchk(1'b1, OFS_AUX_PTR, 8'(a & 8'h7f));
      wr(1'b1, OFS_AUX_WIN, 8'(d));
      mem_m[a & 8'h7f] = d;
      q.push_back(a & 8'h7f);
    end
    foreach (q[k]) begin
      wr(1'b1, OFS_AUX_PTR, 8'(q[k]));
      rdchk(1'b1, OFS_AUX_WIN, 8'(mem_m[q[k]]));
    end
    // window write and read with no idle cycle between the strobes
    d = $urandom & 8'hff;
    @(posedge ref_clk);
    {ctrl_space, reg_addr, reg_wdata, reg_wr} <= {1'b1, OFS_AUX_WIN, 8'(d), 1'b1};
    @(posedge ref_clk);
    {reg_wr, reg_rd} <= 2'b01;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, 8'(d));
    wr(1'b0, OFS_PORT5_DATA, 8'h01);
    wr(1'b1, OFS_PORT6_DIR, 8'h3c);
    rdchk(1'b1, OFS_PORT6_DIR, 8'h00);
    rdchk(1'b1, OFS_AUX_WIN, 8'h00);
    rdchk(1'b0, OFS_PORT5_DATA, {port5_in, 4'h1});
    chk(port6_oe, ~8'(dir_m[6]));
    wr(1'b0, OFS_PORT5_DATA, 8'h00);
    rdchk(1'b1, OFS_PORT6_DIR, 8'(dir_m[6]));
    rdchk(1'b0, 4'h0, 8'h00);
    rdchk(1'b1, 4'hb, 8'h00);
    wr(1'b1, OFS_PORT5_DIR_SEG, 8'h00);
    wr(1'b0, OFS_IRQ_FLAGS, 8'h00);
    fm = 0;
    for (i = 0; i < 7; i++) begin
      @(posedge ref_clk);
      irq_events <= 7'(1 << i);
      @(posedge ref_clk);
      irq_events <= 7'h00;
      fm = fm | (1 << i);
      rdchk(1'b0, OFS_IRQ_FLAGS, 8'(fm));
      v = $urandom & 8'hff;
      wr(1'b0, OFS_IRQ_FLAGS, 8'(v));
      fm = fm & v;
      rdchk(1'b0, OFS_IRQ_FLAGS, 8'(fm));
    end
    // a clearing write and an event in the same cycle: the event must survive
    @(posedge ref_clk);
    {ctrl_space, reg_addr, reg_wdata, reg_wr, irq_events} <= {1'b0, OFS_IRQ_FLAGS, 8'h00, 1'b1, 7'h08};
    @(posedge ref_clk);
    {reg_wr, irq_events} <= 8'h00;
    rdchk(1'b0, OFS_IRQ_FLAGS, 8'h08);
    for (c = 0; c < 4; c++) begin
      v = c[1] ? 8'hff : 8'h00;
      wr(1'b1, OFS_PORT6_DIR, 8'(v));
      wr(1'b1, OFS_PORT8_DIR, 8'(v));
      wr(1'b0, OFS_IRQ_FLAGS, 8'h00);
      @(posedge ref_clk);
      if (c[0]) port8_in <= ~port8_in;
      else port6_in <= ~port6_in;
      repeat (2) @(posedge ref_clk);
      rdchk(1'b0, OFS_IRQ_FLAGS, c[1] ? 8'h80 : 8'h00);
    end
    // pins left high across reset must not raise a false input change
    port6_in <= 8'h5a;
    do_reset();
    tally_and_finish();
  end
endmodule // testbench
